// *** verilog/udc_pkg.sv ***
package udc_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] UDC_CMD_SETUP_WR = 8'hF0;
  localparam logic [7:0] UDC_CMD_SETUP_RD = 8'hF1;
  localparam logic [7:0] UDC_CMD_COUNT_WR = 8'hF2;
  localparam logic [7:0] UDC_CMD_COUNT_RD = 8'hF3;
  localparam logic [7:0] UDC_CMD_FUNC_WR  = 8'hB2;
  localparam logic [7:0] UDC_CMD_FUNC_RD  = 8'hB3;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          UDC_CNT_TERM_BIT   = 15;
  localparam int          UDC_SHORT_BIT      = 14;
  localparam int          UDC_EP_LSB         = 4;
  localparam int          UDC_GO_BIT         = 3;
  localparam int          UDC_BURST_LSB      = 0;
  localparam int          UDC_GLOBAL_EN_BIT  = 15;
  localparam logic [15:0] UDC_SETUP_MASK     = 16'hC0FB;
  localparam logic [15:0] UDC_FUNC_MASK      = 16'h9FFF;
  localparam logic [15:0] UDC_SETUP_RESET    = 16'h0000;
  localparam logic [15:0] UDC_COUNT_RESET    = 16'h0000;
  localparam logic [15:0] UDC_FUNC_RESET     = 16'h0000;

  // Byte phase of a two-byte access
  typedef enum logic [1:0] {UDC_IDLE, UDC_LOW, UDC_HIGH} udc_phase_t;

  // Burst length in bytes for a burst code
  function automatic logic [4:0] udc_burst_bytes(input logic [1:0] code);
    unique case (code)
      2'h0: udc_burst_bytes = 5'h01;
      2'h1: udc_burst_bytes = 5'h04;
      2'h2: udc_burst_bytes = 5'h08;
      2'h3: udc_burst_bytes = 5'h10;
    endcase
  endfunction : udc_burst_bytes

endpackage : udc_pkg

// *** verilog/udc_dma_cfg.sv ***
`timescale 1ns/1ns
`default_nettype none
module udc_dma_cfg
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  // Command interface: command strobe, data write strobe, data read strobe
  input  wire logic       cmd_wr_i,
  input  wire logic       data_wr_i,
  input  wire logic       data_rd_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  // USB side events
  input  wire logic       bus_reset_i,
  input  wire logic       byte_moved_i,
  input  wire logic       short_packet_i,
  input  wire logic       ep_is_out_i,
  // DMA controls
  output logic            dma_global_enable_o,
  output logic            transfer_go_o,
  output logic      [3:0] dma_endpoint_index_o,
  output logic      [4:0] burst_bytes_o,
  output logic            end_of_transfer_o
);

  // ----------------------------------------------------------------
  // Command decode and byte sequencing
  // ----------------------------------------------------------------
  logic [7:0]        cmd_q, cmd_d;
  udc_pkg::udc_phase_t ph_q, ph_d;
  logic [7:0]        lo_q, lo_d;
  logic [7:0]        rdata_q, rdata_d;
  logic [15:0]       setup_q, setup_d;
  logic [15:0]       count_q, count_d;
  logic [15:0]       work_q, work_d;
  logic [15:0]       func_q, func_d;
  logic              eot_q, eot_d;
  logic [15:0]       setup_rd;
  logic [15:0]       rd_word;
  logic              wr_done;
  logic [15:0]       wr_word;
  logic              go;
  logic              en_rise;

  // Setup readback masked to its defined bits, start bit taken as stored in setup_q
  always_comb
  begin
    setup_rd = setup_q & udc_pkg::UDC_SETUP_MASK;
    go = setup_q[udc_pkg::UDC_GO_BIT];
    unique case (cmd_q)
      udc_pkg::UDC_CMD_SETUP_RD: rd_word = setup_rd;
      udc_pkg::UDC_CMD_COUNT_RD: rd_word = work_q;
      udc_pkg::UDC_CMD_FUNC_RD:  rd_word = func_q;
      default:                   rd_word = 16'h0000;
    endcase
  end

  // Phase and data byte handling, low byte first
  always_comb
  begin
    cmd_d   = cmd_q;
    ph_d    = ph_q;
    lo_d    = lo_q;
    rdata_d = rdata_q;
    wr_done = 1'b0;
    wr_word = {wdata_i, lo_q};
    if (cmd_wr_i)
    begin
      cmd_d = wdata_i;
      ph_d  = udc_pkg::UDC_LOW;
    end
    else if (data_wr_i || data_rd_i)
    begin
      unique case (ph_q)
        udc_pkg::UDC_LOW:
        begin
          lo_d    = wdata_i;
          rdata_d = rd_word[7:0];
          ph_d    = udc_pkg::UDC_HIGH;
        end
        udc_pkg::UDC_HIGH:
        begin
          wr_done = data_wr_i;
          rdata_d = rd_word[15:8];
          ph_d    = udc_pkg::UDC_IDLE;
        end
        default: ph_d = udc_pkg::UDC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers and counter
  // ----------------------------------------------------------------
  always_comb
  begin
    setup_d = setup_q;
    count_d = count_q;
    func_d  = func_q;
    work_d  = work_q;
    eot_d   = 1'b0;
    en_rise = 1'b0;
    if (wr_done && cmd_q == udc_pkg::UDC_CMD_SETUP_WR)
      setup_d = wr_word & udc_pkg::UDC_SETUP_MASK;
    if (wr_done && cmd_q == udc_pkg::UDC_CMD_COUNT_WR)
      count_d = wr_word;
    if (wr_done && cmd_q == udc_pkg::UDC_CMD_FUNC_WR)
    begin
      func_d  = wr_word & udc_pkg::UDC_FUNC_MASK;
      en_rise = wr_word[udc_pkg::UDC_GLOBAL_EN_BIT];
    end
    // Working counter: reload on enable, else count moved bytes
    if (en_rise)
      work_d = count_d;
    else if (go && byte_moved_i && work_q != 16'h0000)
      work_d = work_q - 16'h0001;
    // End of transfer: counter expiry or short OUT packet
    if (go && setup_q[udc_pkg::UDC_CNT_TERM_BIT] && byte_moved_i && work_q == 16'h0001)
      eot_d = 1'b1;
    if (go && setup_q[udc_pkg::UDC_SHORT_BIT] && short_packet_i && ep_is_out_i)
      eot_d = 1'b1;
    if (eot_d)
      setup_d[udc_pkg::UDC_GO_BIT] = 1'b0;
    // Bus reset: enable, start bit and end of transfer drop, count kept
    if (bus_reset_i)
    begin
      func_d[udc_pkg::UDC_GLOBAL_EN_BIT] = 1'b0;
      setup_d[udc_pkg::UDC_GO_BIT]       = 1'b0;
      eot_d                              = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cmd_q   <= 8'h00;
      ph_q    <= udc_pkg::UDC_IDLE;
      lo_q    <= 8'h00;
      rdata_q <= 8'h00;
      setup_q <= udc_pkg::UDC_SETUP_RESET;
      count_q <= udc_pkg::UDC_COUNT_RESET;
      work_q  <= udc_pkg::UDC_COUNT_RESET;
      func_q  <= udc_pkg::UDC_FUNC_RESET;
      eot_q   <= 1'b0;
    end
    else
    begin
      cmd_q   <= cmd_d;
      ph_q    <= ph_d;
      lo_q    <= lo_d;
      rdata_q <= rdata_d;
      setup_q <= setup_d;
      count_q <= count_d;
      work_q  <= work_d;
      func_q  <= func_d;
      eot_q   <= eot_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs from flip-flops
  // ----------------------------------------------------------------
  logic [4:0] burst_q;

  // Burst size decoded into a register
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      burst_q <= 5'h01;
    else
      burst_q <= udc_pkg::udc_burst_bytes(setup_d[1:0]);
  end

  assign rdata_o              = rdata_q;
  assign dma_global_enable_o  = func_q[udc_pkg::UDC_GLOBAL_EN_BIT];
  assign transfer_go_o        = setup_q[udc_pkg::UDC_GO_BIT];
  assign dma_endpoint_index_o = setup_q[7:4];
  assign burst_bytes_o        = burst_q;
  assign end_of_transfer_o    = eot_q;

endmodule : udc_dma_cfg
`default_nettype wire

// *** test/udc_dma_cfg_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module udc_dma_cfg_props
(
  // Clock, reset and host strobes
  input wire logic       mclk_i,
  input wire logic       reset_i,
  input wire logic       cmd_wr_i,
  input wire logic       data_wr_i,
  input wire logic [7:0] wdata_i,
  // Events and controls
  input wire logic       bus_reset_i,
  input wire logic       byte_moved_i,
  input wire logic       short_packet_i,
  input wire logic       dma_global_enable_o,
  input wire logic       transfer_go_o,
  input wire logic [3:0] dma_endpoint_index_o,
  input wire logic [4:0] burst_bytes_o,
  input wire logic       end_of_transfer_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Setup write whose low byte carries start bit b
  sequence s_go(b);
    cmd_wr_i && wdata_i == udc_pkg::UDC_CMD_SETUP_WR ##1
    data_wr_i && wdata_i[3] == b ##1 data_wr_i && !bus_reset_i;
  endsequence
  a_go_starts: assert property (s_go(1'h1) |=> transfer_go_o)
    else $error("start lost");
  a_go_stops: assert property (s_go(1'h0) |=> !transfer_go_o)
    else $error("stop lost");
  a_bus_reset:
    assert property (bus_reset_i |=> !(transfer_go_o || dma_global_enable_o))
    else $error("bus reset kept state");
  a_fields_hold:
    assert property (!$stable({dma_endpoint_index_o, burst_bytes_o}) |-> $past(data_wr_i))
    else $error("fields moved");
  a_burst_legal:
    assert property (burst_bytes_o inside {5'h01, 5'h04, 5'h08, 5'h10}) else $error("bad burst");
  a_eot_cause:
    assert property (end_of_transfer_o |-> $past(transfer_go_o && (byte_moved_i || short_packet_i)))
    else $error("eot without cause");
  a_eot_ends:
    assert property (end_of_transfer_o |=> !(end_of_transfer_o || transfer_go_o)) else $error("eot");
  a_en_write:
    assert property ($rose(dma_global_enable_o) |-> $past(data_wr_i)) else $error("enable");
endmodule : udc_dma_cfg_props
bind udc_dma_cfg udc_dma_cfg_props udc_dma_cfg_props_inst (.*);
`default_nettype wire

// *** test/udc_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module udc_host_model
(
  // Host strobes and bytes
  input  wire logic       mclk_i,
  output logic            cmd_wr_o,
  output logic            data_wr_o,
  output logic            data_rd_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i
);
  initial {cmd_wr_o, data_wr_o, data_rd_o, wdata_o} = 11'h000;
  // Command, low byte, high byte
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge mclk_i) {cmd_wr_o, wdata_o} = {1'h1, c};
    @(negedge mclk_i) {cmd_wr_o, data_wr_o, wdata_o} = {2'h1, d[7:0]};
    @(negedge mclk_i) wdata_o = d[15:8];
    @(negedge mclk_i) {data_wr_o, wdata_o} = {1'h0, ~d[15:8]}; // No stale byte
  endtask : wr
  // Command, then two read strobes
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(negedge mclk_i) {cmd_wr_o, wdata_o} = {1'h1, c};
    @(negedge mclk_i) {cmd_wr_o, data_rd_o, wdata_o} = {2'h1, ~c};
    @(negedge mclk_i) d[7:0] = rdata_i;
    @(negedge mclk_i) {data_rd_o, d[15:8]} = {1'h0, rdata_i};
  endtask : rd
endmodule : udc_host_model
`default_nettype wire

// *** test/udc_dma_cfg_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module udc_dma_cfg_tb;
  logic        mclk_i = 1'h0, reset_i = 1'h1, bus_reset_i = 1'h0, byte_moved_i = 1'h0;
  logic        short_packet_i = 1'h0, ep_is_out_i = 1'h0, cmd_wr_i, data_wr_i, data_rd_i;
  logic        dma_global_enable_o, transfer_go_o, end_of_transfer_o;
  logic  [7:0] wdata_i, rdata_o;
  logic  [3:0] dma_endpoint_index_o, r;
  logic  [4:0] burst_bytes_o;
  logic [15:0] v, n, seen_q[$], exp_q[$];
  string       name_q[$];
  int          failures = 0, samples_checked = 0, cycles = 0, eots = 0, e;
  // Clock, pulse count and hang guard
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) eots <= eots + int'(end_of_transfer_o === 1'h1);
  always @(posedge mclk_i) if (++cycles == 3000) report_and_stop(1);
  udc_dma_cfg udc_dma_cfg_inst (.*);
  udc_host_model udc_host_model_inst (.mclk_i(mclk_i), .cmd_wr_o(cmd_wr_i),
    .data_wr_o(data_wr_i), .data_rd_o(data_rd_i), .wdata_o(wdata_i), .rdata_i(rdata_o));
  task automatic report_and_stop(int hung);
    failures += hung;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic note(string s, logic [15:0] g, x);
    name_q.push_back(s);
    seen_q.push_back(g);
    exp_q.push_back(x);
  endtask : note
  task automatic rd(string s, logic [7:0] c, logic [15:0] x);
    udc_host_model_inst.rd(c, v);
    note(s, v, x);
  endtask : rd
  task automatic wr(logic [7:0] c, logic [15:0] d);
    udc_host_model_inst.wr(c, d);
  endtask : wr
  task automatic hold(ref logic s, input int k);
    @(negedge mclk_i) s = 1'h1;
    repeat (k) @(negedge mclk_i);
    s = 1'h0;
    @(negedge mclk_i);
  endtask : hold
  // Reports one mismatch between a seen and an expected value
  task automatic check(string s, logic [15:0] g, x);
    samples_checked++;
    if (g !== x)
    begin
      failures++;
      $display("[FAIL] %s exp %h seen %h", s, x, g);
    end
  endtask : check
  // Compares each noted result with its expectation, on private copies
  always @(negedge mclk_i)
    while (seen_q.size() > 0)
      check(name_q.pop_front(), seen_q.pop_front(), exp_q.pop_front());
  initial
  begin
    void'($urandom(28));
    repeat (5) @(negedge mclk_i);
    reset_i = 1'h0;
    rd("setup", 8'hF1, 16'h0000);
    rd("count", 8'hF3, 16'h0000);
    for (int b = 0; b < 4; b++)
    begin
      r = 4'($urandom());
      wr(8'hF0, {8'hBF, r, 4'h4 | 4'(b)});
      note("ep", 16'(dma_endpoint_index_o), 16'(r));
      note("burst", 16'(burst_bytes_o), b == 0 ? 16'h0001 : 16'h0002 << b);
      rd("setup", 8'hF1, {8'h80, r, 4'(b)});
    end
    wr(8'hF2, 16'h0003);
    wr(8'hB2, 16'h8000);
    note("en", 16'(dma_global_enable_o), 16'h0001);
    wr(8'hF0, 16'h8008); // Short packet mode off while the target is IN
    note("go", 16'(transfer_go_o), 16'h0001);
    e = eots;
    hold(short_packet_i, 1);
    rd("count", 8'hF3, 16'h0003);
    hold(byte_moved_i, 1);
    rd("count", 8'hF3, 16'h0002);
    hold(byte_moved_i, 2);
    note("eot", 16'(eots - e), 16'h0001);
    rd("setup", 8'hF1, 16'h8000);
    n = 16'($urandom_range(200, 4));
    wr(8'hF2, n);
    wr(8'hB2, 16'h8000);
    ep_is_out_i = 1'h1;
    wr(8'hF0, 16'h4008);
    hold(byte_moved_i, 3);
    rd("count", 8'hF3, n - 16'h0003);
    wr(8'hF0, 16'h4000);
    note("go", 16'(transfer_go_o), 16'h0000);
    wr(8'hF0, 16'h4008);
    e = eots;
    hold(short_packet_i, 1);
    note("eot", 16'(eots - e), 16'h0001);
    wr(8'hF0, 16'h80B9);
    hold(bus_reset_i, 1);
    note("go", 16'(transfer_go_o), 16'h0000);
    note("en", 16'(dma_global_enable_o), 16'h0000);
    rd("setup", 8'hF1, 16'h80B1);
    wr(8'hB2, 16'h8000);
    rd("count", 8'hF3, n);
    repeat (2) @(negedge mclk_i);
    report_and_stop(0);
  end
endmodule : udc_dma_cfg_tb
`default_nettype wire
